// ==== design/lkix_pkg.sv ====
// Register map, field layout and types for the lookup index and flood control bank
package lkix_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // Register offsets
   localparam logic [11:0] REG_LUT_STATUS = 12'h314;
   localparam logic [11:0] REG_LUT_MASK   = 12'h315;
   localparam logic [11:0] REG_INDEX0     = 12'h316;
   localparam logic [11:0] REG_INDEX1     = 12'h318;
   localparam logic [11:0] REG_INDEX2     = 12'h31A;
   localparam logic [11:0] REG_UUC_CTRL   = 12'h320;
   localparam logic [11:0] REG_UMC_CTRL   = 12'h324;
   localparam logic [11:0] REG_UVID_CTRL  = 12'h328;

   // Field layout
   localparam int FWD_EN_BIT      = 31;
   localparam int PORT_MASK_W     = 3;
   localparam int ENTRY_IDX_W     = 12;
   localparam int BUCKET_IDX_W    = 10;
   localparam int INDEX_REG_W     = 16;
   localparam int STAT_W          = 3;
   localparam int STAT_LEARN_FAIL = 2;
   localparam int STAT_ALMOST_FULL = 1;
   localparam int STAT_WRITE_FAIL = 0;
   localparam int CNT_W           = 3;

   // Bucket occupancy thresholds, counted in static entries
   localparam logic [2:0] ALMOST_FULL_LO = 3'h2;
   localparam logic [2:0] ALMOST_FULL_HI = 3'h3;
   localparam logic [2:0] BUCKET_FULL    = 3'h4;

   // Reset values
   localparam logic [31:0] CTRL_RST  = 32'h00000000;
   localparam logic [15:0] INDEX_RST = 16'h0000;
   localparam logic [2:0]  STAT_RST  = 3'h0;
   localparam logic [2:0]  MASK_RST  = 3'h7;

   // Writable bits of a forwarding control register
   localparam logic [31:0] CTRL_WMASK = 32'h80000007;

   typedef enum logic [3:0] {
      CAT_NONE  = 4'h1,
      CAT_UVID  = 4'h2,
      CAT_UUC   = 4'h4,
      CAT_UMC   = 4'h8
   } lkix_cat_type;

   function automatic logic [31:0] ctrl_wmask(input logic [31:0] d);
      return d & CTRL_WMASK;
   endfunction

endpackage

// ==== design/lkix_index_reg.sv ====
// Holding register for one captured lookup table index
`timescale 1ns/10ps
`default_nettype none
module lkix_index_reg #(
   parameter int W = 10
) (
   input  wire logic         sys_clk,
   input  wire logic         srst,
   input  wire logic         load,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);

   // Holds until the next capture; reads never touch it
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         q <= '0;
      end else if (load) begin
         q <= d;
      end
   end

endmodule
`default_nettype wire

// ==== design/lkix_flood_select.sv ====
// Unknown-destination category precedence and port selection
`timescale 1ns/10ps
`default_nettype none
module lkix_flood_select (
   input  wire logic                 sys_clk,
   input  wire logic                 srst,
   input  wire logic                 pkt_valid,
   input  wire logic                 pkt_unknown_vid,
   input  wire logic                 pkt_unknown_uc,
   input  wire logic                 pkt_unknown_mc,
   input  wire logic [31:0]          uvid_ctrl,
   input  wire logic [31:0]          uuc_ctrl,
   input  wire logic [31:0]          umc_ctrl,
   output var  logic                 fwd_valid,
   output var  lkix_pkg::lkix_cat_type fwd_cat,
   output var  logic [2:0]           fwd_ports
);

   lkix_pkg::lkix_cat_type next_cat;
   logic [31:0]            sel_ctrl;
   logic [2:0]             next_ports;

   // Unknown VID outranks unicast, which outranks multicast
   assign next_cat = pkt_unknown_vid ? lkix_pkg::CAT_UVID :
                     pkt_unknown_uc  ? lkix_pkg::CAT_UUC  :
                     pkt_unknown_mc  ? lkix_pkg::CAT_UMC  :
                                       lkix_pkg::CAT_NONE;

   assign sel_ctrl = (next_cat == lkix_pkg::CAT_UVID) ? uvid_ctrl :
                     (next_cat == lkix_pkg::CAT_UUC)  ? uuc_ctrl  :
                     (next_cat == lkix_pkg::CAT_UMC)  ? umc_ctrl  :
                                                        lkix_pkg::CTRL_RST;

   // Disabled category floods nowhere; lower ranks are not consulted
   assign next_ports = sel_ctrl[lkix_pkg::FWD_EN_BIT] ?
                       sel_ctrl[lkix_pkg::PORT_MASK_W-1:0] : 3'h0;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         fwd_valid <= 1'b0;
         fwd_cat   <= lkix_pkg::CAT_NONE;
         fwd_ports <= 3'h0;
      end else begin
         fwd_valid <= pkt_valid;
         fwd_cat   <= pkt_valid ? next_cat : lkix_pkg::CAT_NONE;
         fwd_ports <= pkt_valid ? next_ports : 3'h0;
      end
   end

endmodule
`default_nettype wire

// ==== design/lkix_lookup_index_flood.sv ====
// Lookup index capture, status flags and unknown-destination flood control registers
//
// Functional notes
// - A good static write into a bucket with 2 or 3 static entries stores the entry address in the 12-bit field.
// - A failed static write stores the bucket address in the 10-bit field of the same first index register.
// - A learn that fails because the bucket holds 4 static entries stores the bucket address.
// - Every host read or write of the lookup table stores the accessed bucket address.
// - A packet in several unknown categories is handled as unknown VLAN, else unicast, else multicast.
// - The unicast control enable bit 31 turns on flooding of unknown unicast to the masked ports.
// - Unicast control bits 2, 1, 0 select ports 3, 2, 1; a cleared bit excludes the port.
// - The multicast control enable bit 31 turns on flooding of unknown multicast to the masked ports.
// - Multicast control bits 2, 1, 0 select ports 3, 2, 1; a cleared bit excludes the port.
// - All three forwarding control registers reset to all zero, so flooding starts off.
// - Index fields are read-only, reset to zero, and bits above each field read zero.
// - An unknown VLAN control register with its own enable and port mask ranks first.
// - Each capture except a host access also sets its status flag, which the host clears by writing a one.
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module lkix_lookup_index_flood (
   input  wire logic                 sys_clk,
   input  wire logic                 srst,
   // Register port
   input  wire logic [11:0]          reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output var  logic [31:0]          reg_rdata,
   // Lookup engine events
   input  wire logic                 lue_static_wr_ok,
   input  wire logic [2:0]           lue_static_wr_cnt,
   input  wire logic [11:0]          lue_entry_addr,
   input  wire logic                 lue_static_wr_fail,
   input  wire logic                 lue_learn_fail,
   input  wire logic [2:0]           lue_learn_cnt,
   input  wire logic                 lue_host_access,
   input  wire logic [9:0]           lue_bucket_addr,
   // Packet classification
   input  wire logic                 pkt_valid,
   input  wire logic                 pkt_unknown_vid,
   input  wire logic                 pkt_unknown_uc,
   input  wire logic                 pkt_unknown_mc,
   output var  logic                 fwd_valid,
   output var  lkix_pkg::lkix_cat_type fwd_cat,
   output var  logic [2:0]           fwd_ports,
   // Interrupt
   output var  logic                 lut_irq
);

   // Address decode
   logic hit_status;
   logic hit_mask;
   logic hit_index0;
   logic hit_index1;
   logic hit_index2;
   logic hit_uuc;
   logic hit_umc;
   logic hit_uvid;

   assign hit_status = (reg_addr == lkix_pkg::REG_LUT_STATUS);
   assign hit_mask   = (reg_addr == lkix_pkg::REG_LUT_MASK);
   assign hit_index0 = (reg_addr == lkix_pkg::REG_INDEX0);
   assign hit_index1 = (reg_addr == lkix_pkg::REG_INDEX1);
   assign hit_index2 = (reg_addr == lkix_pkg::REG_INDEX2);
   assign hit_uuc    = (reg_addr == lkix_pkg::REG_UUC_CTRL);
   assign hit_umc    = (reg_addr == lkix_pkg::REG_UMC_CTRL);
   assign hit_uvid   = (reg_addr == lkix_pkg::REG_UVID_CTRL);

   // Event qualification
   logic almost_full_evt;
   logic write_fail_evt;
   logic learn_fail_evt;
   logic host_access_evt;

   // Engine reports occupancy before the write
   assign almost_full_evt = lue_static_wr_ok &&
                            (lue_static_wr_cnt == lkix_pkg::ALMOST_FULL_LO ||
                             lue_static_wr_cnt == lkix_pkg::ALMOST_FULL_HI);
   assign write_fail_evt  = lue_static_wr_fail;
   // Learn misses for other reasons are not captured
   assign learn_fail_evt  = lue_learn_fail &&
                            (lue_learn_cnt == lkix_pkg::BUCKET_FULL);
   assign host_access_evt = lue_host_access;

   // Index capture
   logic [11:0] index0_d;
   logic        index0_load;
   logic [11:0] index0_q;
   logic [9:0]  index1_q;
   logic [9:0]  index2_q;

   // A write is either good or failed, never both; failure wins defensively
   assign index0_load = almost_full_evt | write_fail_evt;
   assign index0_d    = write_fail_evt ? {2'h0, lue_bucket_addr} : lue_entry_addr;

   lkix_index_reg #(
      .W (lkix_pkg::ENTRY_IDX_W)
   ) u_index0 (
      .sys_clk (sys_clk),
      .srst    (srst),
      .load    (index0_load),
      .d       (index0_d),
      .q       (index0_q)
   );

   lkix_index_reg #(
      .W (lkix_pkg::BUCKET_IDX_W)
   ) u_index1 (
      .sys_clk (sys_clk),
      .srst    (srst),
      .load    (learn_fail_evt),
      .d       (lue_bucket_addr),
      .q       (index1_q)
   );

   lkix_index_reg #(
      .W (lkix_pkg::BUCKET_IDX_W)
   ) u_index2 (
      .sys_clk (sys_clk),
      .srst    (srst),
      .load    (host_access_evt),
      .d       (lue_bucket_addr),
      .q       (index2_q)
   );

   // Zero-extended views for the read path
   logic [15:0] index0_view;
   logic [15:0] index1_view;
   logic [15:0] index2_view;

   assign index0_view = {4'h0, index0_q};
   assign index1_view = {6'h00, index1_q};
   assign index2_view = {6'h00, index2_q};

   // Forwarding control registers
   logic [31:0] uuc_ctrl;
   logic [31:0] umc_ctrl;
   logic [31:0] uvid_ctrl;
   logic        wr_uuc;
   logic        wr_umc;
   logic        wr_uvid;

   assign wr_uuc  = reg_wr && hit_uuc;
   assign wr_umc  = reg_wr && hit_umc;
   assign wr_uvid = reg_wr && hit_uvid;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         uuc_ctrl  <= lkix_pkg::CTRL_RST;
         umc_ctrl  <= lkix_pkg::CTRL_RST;
         uvid_ctrl <= lkix_pkg::CTRL_RST;
      end else begin
         if (wr_uuc) begin
            uuc_ctrl <= lkix_pkg::ctrl_wmask(reg_wdata);
         end
         if (wr_umc) begin
            umc_ctrl <= lkix_pkg::ctrl_wmask(reg_wdata);
         end
         if (wr_uvid) begin
            uvid_ctrl <= lkix_pkg::ctrl_wmask(reg_wdata);
         end
      end
   end

   // Status flags and mask
   logic [2:0] lut_status;
   logic [2:0] lut_mask;
   logic [2:0] status_set;
   logic [2:0] status_clr;
   logic [2:0] next_status;
   logic       rd_status;
   logic       wr_status;
   logic       wr_mask;

   assign rd_status = reg_rd && hit_status;
   assign wr_status = reg_wr && hit_status;
   assign wr_mask   = reg_wr && hit_mask;

   assign status_set = {learn_fail_evt, almost_full_evt, write_fail_evt};

   // Write-one clears a flag; a read of the register clears all of them
   assign status_clr = (wr_status ? reg_wdata[lkix_pkg::STAT_W-1:0] : 3'h0) |
                       (rd_status ? 3'h7 : 3'h0);

   // Set beats clear so a same-cycle event survives
   assign next_status = (lut_status & ~status_clr) | status_set;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         lut_status <= lkix_pkg::STAT_RST;
         lut_mask   <= lkix_pkg::MASK_RST;
      end else begin
         lut_status <= next_status;
         if (wr_mask) begin
            lut_mask <= reg_wdata[lkix_pkg::STAT_W-1:0];
         end
      end
   end

   // Mask bit set means the source is blocked
   logic next_irq;

   assign next_irq = |(next_status & ~(wr_mask ? reg_wdata[lkix_pkg::STAT_W-1:0] : lut_mask));

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         lut_irq <= 1'b0;
      end else begin
         lut_irq <= next_irq;
      end
   end

   // Read path
   logic [31:0] rd_mux;
   logic [31:0] next_rdata;

   assign rd_mux = hit_status ? {29'h0, lut_status} :
                   hit_mask   ? {29'h0, lut_mask}   :
                   hit_index0 ? {16'h0000, index0_view} :
                   hit_index1 ? {16'h0000, index1_view} :
                   hit_index2 ? {16'h0000, index2_view} :
                   hit_uuc    ? uuc_ctrl  :
                   hit_umc    ? umc_ctrl  :
                   hit_uvid   ? uvid_ctrl :
                                32'h00000000;

   // Data stand one cycle only; zero otherwise
   assign next_rdata = reg_rd ? rd_mux : 32'h00000000;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         reg_rdata <= 32'h00000000;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   // Packet category and destination selection
   lkix_flood_select u_flood (
      .sys_clk         (sys_clk),
      .srst            (srst),
      .pkt_valid       (pkt_valid),
      .pkt_unknown_vid (pkt_unknown_vid),
      .pkt_unknown_uc  (pkt_unknown_uc),
      .pkt_unknown_mc  (pkt_unknown_mc),
      .uvid_ctrl       (uvid_ctrl),
      .uuc_ctrl        (uuc_ctrl),
      .umc_ctrl        (umc_ctrl),
      .fwd_valid       (fwd_valid),
      .fwd_cat         (fwd_cat),
      .fwd_ports       (fwd_ports)
   );

endmodule
`default_nettype wire

// ==== tb/lkix_lookup_index_flood_asserts.sv ====
// Port-level checker for the lookup index and flood control bank
`timescale 1ns/10ps
`default_nettype none
module lkix_lookup_index_flood_asserts (
   input wire logic                   sys_clk,
   input wire logic                   srst,
   input wire logic [11:0]            reg_addr,
   input wire logic                   reg_rd,
   input wire logic [31:0]            reg_rdata,
   input wire logic                   lue_learn_fail,
   input wire logic [2:0]             lue_learn_cnt,
   input wire logic [9:0]             lue_bucket_addr,
   input wire logic                   pkt_valid,
   input wire logic                   pkt_unknown_vid,
   input wire logic                   pkt_unknown_uc,
   input wire logic                   pkt_unknown_mc,
   input wire logic                   fwd_valid,
   input wire lkix_pkg::lkix_cat_type fwd_cat,
   input wire logic [2:0]             fwd_ports
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   wire logic rd_idx = reg_rd && (reg_addr == lkix_pkg::REG_INDEX1 || reg_addr == lkix_pkg::REG_INDEX2);
   wire logic rd_ctl = reg_rd && (reg_addr == lkix_pkg::REG_UUC_CTRL || reg_addr == lkix_pkg::REG_UMC_CTRL);
   wire logic vid = pkt_valid && pkt_unknown_vid;
   wire logic uc = pkt_valid && !pkt_unknown_vid && pkt_unknown_uc;
   wire logic mc = pkt_valid && !pkt_unknown_vid && !pkt_unknown_uc && pkt_unknown_mc;
   sequence learn_ev;
      lue_learn_fail && lue_learn_cnt == lkix_pkg::BUCKET_FULL;
   endsequence
   sequence idx1_rd;
      reg_rd && reg_addr == lkix_pkg::REG_INDEX1;
   endsequence
   idx_hi_a: assert property (rd_idx |=> reg_rdata[31:10] == 22'h000000)
      else $error("index upper bits not zero");
   idx0_hi_a: assert property (reg_rd && reg_addr == lkix_pkg::REG_INDEX0 |=> reg_rdata[31:12] == 20'h00000)
      else $error("first index upper bits not zero");
   ctrl_rsv_a: assert property (rd_ctl |=> reg_rdata[30:3] == 28'h0000000)
      else $error("control reserved bits not zero");
   // Bench reads one idle cycle after the capture edge
   learn_cap_a: assert property (learn_ev ##2 idx1_rd |=> reg_rdata[9:0] == $past(lue_bucket_addr, 3))
      else $error("learn fail bucket not captured");
   fwd_lat_a: assert property (pkt_valid |=> fwd_valid)
      else $error("forward result missing");
   vid_first_a: assert property (vid |=> fwd_cat == lkix_pkg::CAT_UVID)
      else $error("unknown vlan not chosen");
   uc_second_a: assert property (uc |=> fwd_cat == lkix_pkg::CAT_UUC)
      else $error("unknown unicast not chosen");
   mc_third_a: assert property (mc |=> fwd_cat == lkix_pkg::CAT_UMC)
      else $error("unknown multicast not chosen");
   none_cat_a: assert property (pkt_valid && !pkt_unknown_vid && !pkt_unknown_uc && !pkt_unknown_mc
                                |=> fwd_cat == lkix_pkg::CAT_NONE && fwd_ports == 3'h0)
      else $error("known packet flooded");
endmodule
bind lkix_lookup_index_flood lkix_lookup_index_flood_asserts u_chk (.sys_clk(sys_clk), .srst(srst),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lue_learn_fail(lue_learn_fail),
   .lue_learn_cnt(lue_learn_cnt), .lue_bucket_addr(lue_bucket_addr), .pkt_valid(pkt_valid),
   .pkt_unknown_vid(pkt_unknown_vid), .pkt_unknown_uc(pkt_unknown_uc), .pkt_unknown_mc(pkt_unknown_mc),
   .fwd_valid(fwd_valid), .fwd_cat(fwd_cat), .fwd_ports(fwd_ports));
`default_nettype wire

// ==== tb/lkix_lue_model.sv ====
// Lookup engine model issuing capture events
`timescale 1ns/10ps
`default_nettype none
module lkix_lue_model (
   input  wire logic        sys_clk,
   output var  logic        wr_ok,
   output var  logic [2:0]  wr_cnt,
   output var  logic [11:0] entry,
   output var  logic        wr_fail,
   output var  logic        learn,
   output var  logic [2:0]  learn_cnt,
   output var  logic        host,
   output var  logic [9:0]  bucket
);
   initial begin
      {wr_ok, wr_fail, learn, host} = 4'h0;
      {wr_cnt, learn_cnt, entry, bucket} = 28'h0000000;
   end
   // Kind 0 good write, 1 failed write, 2 learn fail, 3 host access
   task automatic ev(input int k, input logic [2:0] c, input logic [11:0] e, input logic [9:0] b);
      @(posedge sys_clk);
      wr_ok <= (k == 0);
      wr_fail <= (k == 1);
      learn <= (k == 2);
      host <= (k == 3);
      wr_cnt <= c;
      learn_cnt <= c;
      entry <= e;
      bucket <= b;
      @(posedge sys_clk);
      {wr_ok, wr_fail, learn, host} <= 4'h0;
      // Stale address must not look valid
      entry <= ~e;
      bucket <= ~b;
   endtask
endmodule
`default_nettype wire

// ==== tb/lkix_lookup_index_flood_tb.sv ====
// Self-checking bench for the lookup index and flood control bank
`timescale 1ns/10ps
`default_nettype none
module lkix_lookup_index_flood_tb;
   logic                   sys_clk = 1'b0;
   logic                   srst = 1'b1;
   logic [11:0]            reg_addr = 12'h000;
   logic [31:0]            reg_wdata = 32'h00000000;
   logic                   reg_wr = 1'b0;
   logic                   reg_rd = 1'b0;
   logic [31:0]            reg_rdata;
   logic                   wr_ok, wr_fail, learn, host;
   logic [2:0]             wr_cnt, learn_cnt;
   logic [11:0]            entry;
   logic [9:0]             bucket;
   logic                   pkt_valid = 1'b0;
   logic                   p_vid = 1'b0;
   logic                   p_uc = 1'b0;
   logic                   p_mc = 1'b0;
   logic                   fwd_valid, lut_irq;
   lkix_pkg::lkix_cat_type fwd_cat;
   logic [2:0]             fwd_ports;
   int                     failures = 0;
   int                     checks_done = 0;
   always #25 sys_clk = ~sys_clk;
   lkix_lue_model u_lue (.sys_clk(sys_clk), .wr_ok(wr_ok), .wr_cnt(wr_cnt), .entry(entry),
      .wr_fail(wr_fail), .learn(learn), .learn_cnt(learn_cnt), .host(host), .bucket(bucket));
   lkix_lookup_index_flood DUT (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lue_static_wr_ok(wr_ok),
      .lue_static_wr_cnt(wr_cnt), .lue_entry_addr(entry), .lue_static_wr_fail(wr_fail),
      .lue_learn_fail(learn), .lue_learn_cnt(learn_cnt), .lue_host_access(host), .lue_bucket_addr(bucket),
      .pkt_valid(pkt_valid), .pkt_unknown_vid(p_vid), .pkt_unknown_uc(p_uc), .pkt_unknown_mc(p_mc),
      .fwd_valid(fwd_valid), .fwd_cat(fwd_cat), .fwd_ports(fwd_ports), .lut_irq(lut_irq));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   task automatic t_reset;
      logic [11:0] a[9] = '{12'h314, 12'h315, 12'h316, 12'h318, 12'h31A, 12'h320, 12'h324, 12'h328, 12'h321};
      for (int i = 0; i < 9; i++) begin
         rchk(a[i], (a[i] == lkix_pkg::REG_LUT_MASK) ? 32'h00000007 : 32'h00000000);
      end
   endtask
   task automatic t_ctrl;
      logic [11:0] a[7] = '{12'h320, 12'h324, 12'h328, 12'h316, 12'h318, 12'h31A, 12'h321};
      for (int i = 0; i < 7; i++) begin
         wr(a[i], 32'hFFFFFFFF);
         rchk(a[i], (i < 3) ? lkix_pkg::CTRL_WMASK : 32'h00000000);
         wr(a[i], 32'h00000000);
      end
   endtask
   task automatic t_index;
      u_lue.ev(0, 3'h2, 12'hABC, 10'h000);
      rchk(lkix_pkg::REG_INDEX0, 32'h00000ABC);
      u_lue.ev(0, 3'h3, 12'h5A3, 10'h000);
      rchk(lkix_pkg::REG_INDEX0, 32'h000005A3);
      u_lue.ev(0, 3'h1, 12'h777, 10'h000);
      rchk(lkix_pkg::REG_INDEX0, 32'h000005A3);
      u_lue.ev(1, 3'h0, 12'h000, 10'h2A5);
      rchk(lkix_pkg::REG_INDEX0, 32'h000002A5);
      u_lue.ev(2, 3'h4, 12'h000, 10'h155);
      rchk(lkix_pkg::REG_INDEX1, 32'h00000155);
      u_lue.ev(2, 3'h3, 12'h000, 10'h0AA);
      rchk(lkix_pkg::REG_INDEX1, 32'h00000155);
      u_lue.ev(3, 3'h0, 12'h000, 10'h3FF);
      rchk(lkix_pkg::REG_INDEX2, 32'h000003FF);
      rchk(lkix_pkg::REG_INDEX2, 32'h000003FF);
      rchk(lkix_pkg::REG_LUT_STATUS, 32'h00000007);
   endtask
   task automatic t_irq;
      wr(lkix_pkg::REG_LUT_MASK, 32'h00000003);
      u_lue.ev(2, 3'h4, 12'h000, 10'h001);
      #1 chk({31'h0, lut_irq}, 32'h1);
      rchk(lkix_pkg::REG_LUT_STATUS, 32'h00000004);
      chk({31'h0, lut_irq}, 32'h0);
      u_lue.ev(0, 3'h2, 12'h010, 10'h000);
      #1 chk({31'h0, lut_irq}, 32'h0);
      u_lue.ev(2, 3'h4, 12'h000, 10'h002);
      #1 chk({31'h0, lut_irq}, 32'h1);
      wr(lkix_pkg::REG_LUT_STATUS, 32'h00000004);
      chk({31'h0, lut_irq}, 32'h0);
      rchk(lkix_pkg::REG_LUT_STATUS, 32'h00000002);
      wr(lkix_pkg::REG_LUT_MASK, 32'h00000007);
   endtask
   task automatic t_flood;
      logic [11:0] a[3] = '{12'h328, 12'h320, 12'h324};
      lkix_pkg::lkix_cat_type cats[4] = '{lkix_pkg::CAT_UVID, lkix_pkg::CAT_UUC, lkix_pkg::CAT_UMC, lkix_pkg::CAT_NONE};
      logic [2:0] mk[4];
      int c;
      // Rotated masks reach every port bit; last pass has enables off
      for (int p = 0; p < 4; p++) begin
         for (int i = 0; i < 3; i++) begin
            mk[i] = (p < 3) ? (3'h1 << ((i + p) % 3)) : 3'h7;
            wr(a[i], {(p < 3), 28'h0000000, mk[i]});
         end
         mk[3] = 3'h0;
         for (int k = 0; k < 8; k++) begin
            c = k[2] ? 0 : k[1] ? 1 : k[0] ? 2 : 3;
            @(posedge sys_clk);
            pkt_valid <= 1'b1;
            {p_vid, p_uc, p_mc} <= k[2:0];
            @(posedge sys_clk);
            pkt_valid <= 1'b0;
            #1 chk({28'h0000000, fwd_cat}, {28'h0000000, cats[c]});
            chk({fwd_valid, fwd_ports}, {1'b1, (p < 3) ? mk[c] : 3'h0});
         end
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      srst <= 1'b0;
      t_reset;
      t_ctrl;
      t_index;
      t_irq;
      t_flood;
      end_of_test;
   end
   // Run needs about 204 cycles
   initial begin
      #500000;
      failures++;
      end_of_test;
   end
endmodule
`default_nettype wire
